/* hdl/pdo_override.sv */
// Port D alternate function override: direction, value, pull-up and input routing
//
// What this block does
// RULE1 - Receiver enabled forces pin 4 input
// RULE2 - Forced-input pin 4 pull-up from value bit
// RULE3 - SPI slave forces clock pin 4 input
// RULE4 - SPI master: pin 4 follows direction bit
// RULE5 - SPI forced pin 4 pull-up from value
// RULE6 - Transmitter enabled forces pin 3 output
// RULE7 - Timer0 compare reaches pin 3 if direction
// RULE8 - External master drives slave select low
// RULE9 - SPI slave forces select pin 3 input unless the transmitter is enabled
// RULE10 - Data pin 3: slave input, master direction bit
// RULE11 - SPI master forces pin 2 input
// RULE12 - Slave pin 2 follows direction; pull-up kept
// RULE13 - Timer1 compare reaches pin 2 if direction
// RULE14 - Fuse drives divided clock on pin 1
// RULE15 - Divided clock continues during reset
// RULE16 - Pin 6 feeds external interrupt zero
// RULE17 - Pin 4 feeds timer1 capture input
// RULE18 - Software keeps comparator pins input, no pull-up
// RULE19 - Pins 7..0 feed pin-change sources 23..16
// RULE20 - Pin 3 value: transmit, compare, then SPI
// RULE21 - Unoverridden pins follow ordinary port bits
`timescale 1ns/1ps

module pdo_override #(
    parameter int WIDTH = pdo_pkg::PORT_WIDTH
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire pdo_pkg::pdo_port_s port_ctl,
    input wire pdo_pkg::pdo_periph_s periph,
    input wire logic clock_output_fuse,
    input wire logic divided_clock,
    input wire logic [WIDTH-1:0] digital_in_off,
    input wire logic [WIDTH-1:0] pad_in,
    output logic [WIDTH-1:0] pad_oe,
    output logic [WIDTH-1:0] pad_out,
    output logic [WIDTH-1:0] pad_pullup,
    output logic [WIDTH-1:0] pin_level,
    output logic [WIDTH-1:0] pin_change_src,
    output logic external_irq_zero,
    output logic timer1_capture_in,
    output logic serial_receive_data,
    output logic spi_clk_in,
    output logic spi_ss_n_in,
    output logic spi_mosi_in,
    output logic spi_miso_in
);

    // -------------------------------------------------------------------
    // Override conditions
    // -------------------------------------------------------------------
    logic spi_here;
    logic spi_slave;
    logic spi_mstr;
    logic [WIDTH-1:0] dir_next;
    logic [WIDTH-1:0] val_next;
    logic [WIDTH-1:0] pu_next;
    logic [WIDTH-1:0] din_on;
    logic [WIDTH-1:0] din_gated;
    logic [WIDTH-1:0] pad_oe_reg;
    logic [WIDTH-1:0] pad_out_reg;
    logic [WIDTH-1:0] pad_pullup_reg;
    logic [WIDTH-1:0] pin_level_reg;
    logic [WIDTH-1:0] pin_change_reg;
    logic irq0_reg;
    logic capture_reg;
    logic rx_data_reg;
    logic sck_in_reg;
    logic ss_n_reg;
    logic mosi_in_reg;
    logic miso_in_reg;

    // SPI only owns these pins when routed to port D
    assign spi_here = periph.spi_on & periph.spi_pin_select;
    assign spi_slave = spi_here & ~periph.spi_master;
    assign spi_mstr = spi_here & periph.spi_master;

    // -------------------------------------------------------------------
    // Next pad direction
    // -------------------------------------------------------------------
    always_comb begin
        // RULE21 default direction
        dir_next = port_ctl.direction_bit;
        // RULE1 receiver input
        // RULE3 slave clock input
        // RULE4 master clock direction
        if (periph.rx_on | spi_slave) begin
            dir_next[pdo_pkg::PIN_RX] = 1'b0;
        end
        // RULE6 transmitter output
        // RULE9 slave select input
        // RULE10 data pin direction
        if (periph.transmitter_on) begin
            dir_next[pdo_pkg::PIN_TX] = 1'b1;
        end else if (spi_slave) begin
            dir_next[pdo_pkg::PIN_TX] = 1'b0;
        end
        // RULE11 master data input
        // RULE12 slave data direction
        if (spi_mstr) begin
            dir_next[pdo_pkg::PIN_MISO] = 1'b0;
        end
        // RULE14 clock pin output
        if (clock_output_fuse) begin
            dir_next[pdo_pkg::PIN_DIVIDED_CLOCK_PIN] = 1'b1;
        end
    end

    // -------------------------------------------------------------------
    // Next pad value
    // -------------------------------------------------------------------
    always_comb begin
        // RULE21 default value
        val_next = port_ctl.output_value;
        if (spi_mstr) begin
            val_next[pdo_pkg::PIN_RX] = periph.spi_clk_out;
        end
        // RULE20 value priority
        // RULE7 timer0 compare
        if (periph.transmitter_on) begin
            val_next[pdo_pkg::PIN_TX] = periph.tx_data;
        end else if (periph.compare_out_on) begin
            val_next[pdo_pkg::PIN_TX] = periph.timer0_compare_a_out;
        end else if (spi_mstr) begin
            val_next[pdo_pkg::PIN_TX] = periph.spi_mosi_out;
        end
        // RULE13 timer1 compare
        if (periph.timer1_compare_on) begin
            val_next[pdo_pkg::PIN_MISO] = periph.timer1_compare_a_out;
        end else if (spi_slave) begin
            val_next[pdo_pkg::PIN_MISO] = periph.spi_miso_out;
        end
    end

    // -------------------------------------------------------------------
    // Pull-up and digital input gating, per pin
    // -------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_pin
            // RULE2 forced input pull-up
            // RULE5 SPI pull-up kept
            // RULE12 forced pull-up kept
            // RULE21 default pull-up
            // Pull-up only on a pin that ends up an input, whatever forced it
            assign pu_next[gi] = ~dir_next[gi] & port_ctl.output_value[gi] & ~port_ctl.pullup_off;
            // RULE18 analog pins relieved
            // Interrupt zero, when enabled, keeps its digital input even when analog use disables it
            if (gi == pdo_pkg::PIN_IRQ0) begin : g_irq
                assign din_on[gi] = ~digital_in_off[gi] | periph.external_irq_zero_on;
            end else begin : g_plain
                assign din_on[gi] = ~digital_in_off[gi];
            end
            assign din_gated[gi] = pad_in[gi] & din_on[gi];
        end
    endgenerate

    // -------------------------------------------------------------------
    // Pad drive registers
    // -------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pad_oe_reg <= pdo_pkg::RST_PAD_OE;
        end else begin
            pad_oe_reg <= dir_next;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pad_out_reg <= pdo_pkg::RST_PAD_OUT;
        end else begin
            pad_out_reg <= val_next;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pad_pullup_reg <= pdo_pkg::RST_PAD_PULLUP;
        end else begin
            pad_pullup_reg <= pu_next;
        end
    end

    // -------------------------------------------------------------------
    // Input routing to peripherals
    // -------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pin_level_reg <= pdo_pkg::RST_PIN_LEVEL;
            pin_change_reg <= pdo_pkg::RST_PIN_LEVEL;
        end else begin
            pin_level_reg <= din_gated;
            // RULE19 pin-change sources
            pin_change_reg <= din_gated;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            irq0_reg <= pdo_pkg::RST_SENSE;
            capture_reg <= pdo_pkg::RST_SENSE;
            rx_data_reg <= pdo_pkg::RST_SENSE;
        end else begin
            // RULE16 interrupt zero source
            irq0_reg <= din_gated[pdo_pkg::PIN_IRQ0];
            // RULE17 capture source
            capture_reg <= din_gated[pdo_pkg::PIN_RX];
            rx_data_reg <= din_gated[pdo_pkg::PIN_RX];
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            sck_in_reg <= pdo_pkg::RST_SENSE;
            ss_n_reg <= pdo_pkg::RST_SS_N;
            mosi_in_reg <= pdo_pkg::RST_SENSE;
            miso_in_reg <= pdo_pkg::RST_SENSE;
        end else begin
            sck_in_reg <= din_gated[pdo_pkg::PIN_RX];
            // RULE8 select from master
            // Unrouted SPI sees select high so it never wakes on stray levels
            ss_n_reg <= spi_here ? din_gated[pdo_pkg::PIN_TX] : 1'b1;
            mosi_in_reg <= din_gated[pdo_pkg::PIN_TX];
            miso_in_reg <= din_gated[pdo_pkg::PIN_MISO];
        end
    end

    // -------------------------------------------------------------------
    // Outputs
    // -------------------------------------------------------------------
    // RULE15 clock through reset
    // Clock pin bypasses the reset flops so the fuse keeps it running in reset
    assign pad_oe = clock_output_fuse ? (pad_oe_reg | {{(WIDTH-2){1'b0}}, 1'b1, 1'b0}) : pad_oe_reg;
    // RULE14 divided clock value
    assign pad_out = clock_output_fuse
        ? {pad_out_reg[WIDTH-1:2], divided_clock, pad_out_reg[0]} : pad_out_reg;
    assign pad_pullup = pad_pullup_reg;
    assign pin_level = pin_level_reg;
    assign pin_change_src = pin_change_reg;
    assign external_irq_zero = irq0_reg;
    assign timer1_capture_in = capture_reg;
    assign serial_receive_data = rx_data_reg;
    assign spi_clk_in = sck_in_reg;
    assign spi_ss_n_in = ss_n_reg;
    assign spi_mosi_in = mosi_in_reg;
    assign spi_miso_in = miso_in_reg;

    // -------------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------------
    property p_rx_input;
        @(posedge core_clk) disable iff (!nrst)
        periph.rx_on |=> !pad_oe[4];
    endproperty
    a_rx_input: assert property (p_rx_input) else $error("receiver did not force pin 4 input"); // RULE1

    property p_rx_pullup;
        @(posedge core_clk) disable iff (!nrst)
        (periph.rx_on && port_ctl.output_value[4] && !port_ctl.pullup_off) |=> pad_pullup[4];
    endproperty
    a_rx_pullup: assert property (p_rx_pullup) else $error("pin 4 pull-up missing under receiver"); // RULE2

    property p_slave_clk;
        @(posedge core_clk) disable iff (!nrst)
        // Transmitter keeps pin 3 an output even in slave role
        spi_slave |=> (!pad_oe[4] && (!pad_oe[3] || $past(periph.transmitter_on)));
    endproperty
    a_slave_clk: assert property (p_slave_clk) else $error("slave did not force pins 4 and 3 input"); // RULE3

    property p_master_clk;
        @(posedge core_clk) disable iff (!nrst)
        (spi_mstr && !periph.rx_on) |=> (pad_oe[4] == $past(port_ctl.direction_bit[4]));
    endproperty
    a_master_clk: assert property (p_master_clk) else $error("master clock pin ignored direction bit"); // RULE4

    property p_tx_output;
        @(posedge core_clk) disable iff (!nrst)
        periph.transmitter_on |=> (pad_oe[3] && pad_out[3] == $past(periph.tx_data) && !pad_pullup[3]);
    endproperty
    a_tx_output: assert property (p_tx_output) else $error("transmitter did not drive pin 3"); // RULE6

    property p_oc0_value;
        @(posedge core_clk) disable iff (!nrst)
        (!periph.transmitter_on && periph.compare_out_on) |=> (pad_out[3] == $past(periph.timer0_compare_a_out));
    endproperty
    a_oc0_value: assert property (p_oc0_value) else $error("pin 3 value priority wrong"); // RULE20

    property p_master_miso;
        @(posedge core_clk) disable iff (!nrst)
        spi_mstr |=> (!pad_oe[2] && pad_pullup[2] == $past(port_ctl.output_value[2] && !port_ctl.pullup_off));
    endproperty
    a_master_miso: assert property (p_master_miso) else $error("master did not force pin 2 input"); // RULE11

    property p_oc1_value;
        @(posedge core_clk) disable iff (!nrst)
        periph.timer1_compare_on ##1 (pad_oe[2] && periph.timer1_compare_on) |-> pad_out[2] == $past(periph.timer1_compare_a_out);
    endproperty
    a_oc1_value: assert property (p_oc1_value) else $error("timer1 compare not on pin 2"); // RULE13

    property p_clk_out;
        @(posedge core_clk)
        clock_output_fuse |-> (pad_oe[1] && pad_out[1] == divided_clock);
    endproperty
    a_clk_out: assert property (p_clk_out) else $error("divided clock absent on pin 1"); // RULE15

    property p_pin_change;
        @(posedge core_clk) disable iff (!nrst)
        nrst |=> (pin_change_src == $past(din_gated) && external_irq_zero == $past(din_gated[6]));
    endproperty
    a_pin_change: assert property (p_pin_change) else $error("pin-change or interrupt source mismatch"); // RULE19

    property p_default;
        @(posedge core_clk) disable iff (!nrst)
        nrst |=> (pad_oe[0] == $past(port_ctl.direction_bit[0]) && pad_out[7:5] == $past(port_ctl.output_value[7:5]));
    endproperty
    a_default: assert property (p_default) else $error("plain pin did not follow port bits"); // RULE21

    property p_slave_miso;
        @(posedge core_clk) disable iff (!nrst)
        spi_slave |=> (pad_oe[2] == $past(port_ctl.direction_bit[2]));
    endproperty
    a_slave_miso: assert property (p_slave_miso) else $error("slave data pin ignored direction bit"); // RULE12

    property p_master_mosi;
        @(posedge core_clk) disable iff (!nrst)
        (spi_mstr && !periph.transmitter_on) |=> (pad_oe[3] == $past(port_ctl.direction_bit[3]));
    endproperty
    a_master_mosi: assert property (p_master_mosi) else $error("master data pin ignored direction bit"); // RULE10

    property p_slave_pullup;
        @(posedge core_clk) disable iff (!nrst)
        (spi_slave && port_ctl.output_value[4] && !port_ctl.pullup_off) |=> pad_pullup[4];
    endproperty
    a_slave_pullup: assert property (p_slave_pullup) else $error("pin 4 pull-up missing under slave"); // RULE5

    property p_capture;
        @(posedge core_clk) disable iff (!nrst)
        nrst |=> (timer1_capture_in == $past(din_gated[4]) && serial_receive_data == $past(din_gated[4]));
    endproperty
    a_capture: assert property (p_capture) else $error("pin 4 not routed to capture or receiver"); // RULE17

    property p_select;
        @(posedge core_clk) disable iff (!nrst)
        (nrst && spi_slave) |=> (spi_ss_n_in == $past(din_gated[3]));
    endproperty
    a_select: assert property (p_select) else $error("slave select not taken from pin 3"); // RULE8

endmodule // pdo_override

/* hdl/pdo_pkg.sv */
// Constants and carrier types for the port D alternate function override
package pdo_pkg;

    // -------------------------------------------------------------------
    // Port geometry
    // -------------------------------------------------------------------
    localparam int PORT_WIDTH = 8;
    localparam int PIN_DIVIDED_CLOCK_PIN = 1;
    localparam int PIN_MISO = 2;
    localparam int PIN_TX = 3;
    localparam int PIN_RX = 4;
    localparam int PIN_IRQ0 = 6;
    // Pin-change source number carried by pin 0; pin k maps to this plus k
    localparam int PCHG_SRC_BASE = 16;

    // -------------------------------------------------------------------
    // Reset values of the registered pad and sense outputs
    // -------------------------------------------------------------------
    localparam logic [7:0] RST_PAD_OE = 8'h00;
    localparam logic [7:0] RST_PAD_OUT = 8'h00;
    localparam logic [7:0] RST_PAD_PULLUP = 8'h00;
    localparam logic [7:0] RST_PIN_LEVEL = 8'h00;
    localparam logic RST_SENSE = 1'b0;
    // Slave select idles high so a reset SPI slave stays inactive
    localparam logic RST_SS_N = 1'b1;

    // -------------------------------------------------------------------
    // Carrier types
    // -------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] direction_bit;
        logic [7:0] output_value;
        logic pullup_off;
    } pdo_port_s;

    typedef struct packed {
        logic rx_on;
        logic transmitter_on;
        logic tx_data;
        logic spi_on;
        logic spi_master;
        logic spi_pin_select;
        logic spi_clk_out;
        logic spi_mosi_out;
        logic spi_miso_out;
        logic compare_out_on;
        logic timer0_compare_a_out;
        logic timer1_compare_on;
        logic timer1_compare_a_out;
        logic external_irq_zero_on;
    } pdo_periph_s;

endpackage : pdo_pkg

/* tb/pdo_pads.sv */
// Far-side pad model: resolves each pin's wire level from every driver
`timescale 1ns/1ps

module pdo_pads (
    input wire logic core_clk,
    input wire logic [7:0] pad_oe,
    input wire logic [7:0] pad_out,
    input wire logic [7:0] pad_pullup,
    input wire logic [7:0] ext_en,
    input wire logic [7:0] ext_val,
    output logic [7:0] pad_in
);
    // -------------------------------------------------------------------
    // Wire resolution
    // -------------------------------------------------------------------
    // Floating pins wander so a stale level is never trusted
    logic [7:0] float_reg = 8'h96;

    always @(posedge core_clk) begin
        float_reg <= ~float_reg;
    end

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pad_oe[i])
                pad_in[i] = pad_out[i];
            else if (ext_en[i])
                pad_in[i] = ext_val[i];
            else if (pad_pullup[i])
                pad_in[i] = 1'b1;
            else
                pad_in[i] = float_reg[i];
        end
    end
endmodule // pdo_pads

/* tb/tb.sv */
// Self-checking bench for the port D override block
`timescale 1ns/1ps

module tb;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    pdo_pkg::pdo_port_s ctl = '0;
    pdo_pkg::pdo_periph_s per = '0;
    logic fuse = 1'b0;
    logic dclk = 1'b0;
    logic [7:0] din_off = 8'h00;
    logic [7:0] een = 8'h00;
    logic [7:0] evl = 8'h00;
    logic [7:0] pad_in, pad_oe, pad_out, pad_pullup, pin_level, pin_change_src;
    logic eirq, cap, rxd, sck_in, ss_n, mosi_in, miso_in;
    int err_total = 0;
    int n_tests = 0;

    pdo_override dut_u (.core_clk(core_clk), .nrst(nrst), .port_ctl(ctl), .periph(per),
        .clock_output_fuse(fuse), .divided_clock(dclk), .digital_in_off(din_off), .pad_in(pad_in),
        .pad_oe(pad_oe), .pad_out(pad_out), .pad_pullup(pad_pullup), .pin_level(pin_level),
        .pin_change_src(pin_change_src), .external_irq_zero(eirq), .timer1_capture_in(cap),
        .serial_receive_data(rxd), .spi_clk_in(sck_in), .spi_ss_n_in(ss_n), .spi_mosi_in(mosi_in),
        .spi_miso_in(miso_in));

    pdo_pads pads_u (.core_clk(core_clk), .pad_oe(pad_oe), .pad_out(pad_out),
        .pad_pullup(pad_pullup), .ext_en(een), .ext_val(evl), .pad_in(pad_in));

    // -------------------------------------------------------------------
    // Shared tasks
    // -------------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic end_sim;
        $display("checks=%0d mismatches=%0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic tick;
        @(posedge core_clk);
        #1;
    endtask

    // Outputs are registered, so results are read 1ns after the edge that samples the driven inputs
    task automatic drv(input logic [7:0] dir, input logic [7:0] val, input logic poff,
                       input pdo_pkg::pdo_periph_s p, input logic [7:0] en, input logic [7:0] ev);
        @(posedge core_clk);
        ctl <= {dir, val, poff};
        per <= p;
        een <= en;
        evl <= ev;
        tick;
    endtask

    // -------------------------------------------------------------------
    // Scenarios
    // -------------------------------------------------------------------
    task automatic t_plain;
        pdo_pkg::pdo_periph_s p;
        p = '0;
        drv(8'h5a, 8'h3c, 1'b0, p, 8'h00, 8'h00);
        chk(pad_oe, 8'h5a);
        chk(pad_out & 8'h5a, 8'h18);
        chk(pad_pullup, 8'h24);
        drv(8'h5a, 8'h3c, 1'b1, p, 8'h00, 8'h00);
        chk(pad_pullup, 8'h00);
        p.rx_on = 1'b1;
        drv(8'hff, 8'hff, 1'b0, p, 8'h00, 8'h00);
        chk(pad_oe, 8'hef);
        chk(pad_pullup, 8'h10);
        drv(8'hff, 8'hef, 1'b0, p, 8'h00, 8'h00);
        chk(pad_pullup, 8'h00);
        $display("plain and receive test done");
    endtask

    task automatic t_slave;
        pdo_pkg::pdo_periph_s p;
        p = '0;
        p.spi_on = 1'b1;
        p.spi_pin_select = 1'b1;
        p.spi_miso_out = 1'b1;
        for (int s = 0; s < 2; s++) begin
            drv(8'hff, 8'hff, 1'b0, p, 8'h08, {4'h0, s[0], 3'h0});
            tick;
            chk(pad_oe[4:2], 3'b001);
            chk(pad_pullup[4:2], 3'b110);
            chk(pad_out[2], 1'b1);
            chk({ss_n, mosi_in}, {s[0], s[0]});
        end
        p.spi_pin_select = 1'b0;
        drv(8'hff, 8'hff, 1'b0, p, 8'h08, 8'h00);
        tick;
        chk({ss_n, pad_oe[4]}, 2'b11);
        p.spi_pin_select = 1'b1;
        p.spi_master = 1'b1;
        p.spi_clk_out = 1'b1;
        p.spi_mosi_out = 1'b1;
        for (int d = 0; d < 2; d++) begin
            drv({8{d[0]}}, 8'h04, 1'b0, p, 8'h00, 8'h00);
            chk(pad_oe[4:2], {d[0], d[0], 1'b0});
            chk(pad_pullup[4:2], 3'b001);
            if (d == 1)
                chk(pad_out[4:3], 2'b11);
        end
        $display("spi test done");
    endtask

    task automatic t_compare;
        pdo_pkg::pdo_periph_s p;
        for (int b = 0; b < 2; b++) begin
            p = '0;
            p.transmitter_on = 1'b1;
            p.tx_data = b[0];
            p.compare_out_on = 1'b1;
            p.timer0_compare_a_out = ~b[0];
            p.spi_on = 1'b1;
            p.spi_pin_select = 1'b1;
            drv(8'h00, 8'h00, 1'b0, p, 8'h00, 8'h00);
            chk({pad_oe[3], pad_out[3]}, {1'b1, b[0]});
            p.transmitter_on = 1'b0;
            p.spi_master = 1'b1;
            p.spi_mosi_out = ~b[0];
            p.timer0_compare_a_out = b[0];
            drv(8'h08, 8'h00, 1'b0, p, 8'h00, 8'h00);
            chk({pad_oe[3], pad_out[3]}, {1'b1, b[0]});
            drv(8'h00, 8'h00, 1'b0, p, 8'h00, 8'h00);
            chk(pad_oe[3], 1'b0);
            p.compare_out_on = 1'b0;
            p.spi_mosi_out = b[0];
            drv(8'h08, 8'h00, 1'b0, p, 8'h00, 8'h00);
            chk(pad_out[3], b[0]);
            p = '0;
            p.spi_on = 1'b1;
            p.spi_pin_select = 1'b1;
            p.spi_miso_out = ~b[0];
            p.timer1_compare_on = 1'b1;
            p.timer1_compare_a_out = b[0];
            drv(8'h04, 8'h00, 1'b0, p, 8'h00, 8'h00);
            chk({pad_oe[2], pad_out[2]}, {1'b1, b[0]});
            drv(8'h00, 8'h00, 1'b0, p, 8'h00, 8'h00);
            chk(pad_oe[2], 1'b0);
        end
        $display("output priority test done");
    endtask

    task automatic t_inputs;
        pdo_pkg::pdo_periph_s p;
        logic [7:0] pat;
        p = '0;
        p.external_irq_zero_on = 1'b1;
        @(posedge core_clk);
        din_off <= 8'he1;
        for (int i = 0; i < 2; i++) begin
            pat = i ? 8'h5a : 8'ha5;
            drv(8'h00, 8'h00, 1'b1, p, 8'hff, pat);
            tick;
            chk(pin_change_src, pat & 8'h5e);
            chk(pin_level, pat & 8'h5e);
            chk({eirq, cap}, {pat[6], pat[4]});
            chk({rxd, sck_in, mosi_in, miso_in, ss_n}, {pat[4], pat[4], pat[3], pat[2], 1'b1});
        end
        $display("input routing test done");
    endtask

    task automatic t_divided_clock_pin;
        pdo_pkg::pdo_periph_s p;
        p = '0;
        drv(8'h00, 8'h00, 1'b0, p, 8'h00, 8'h00);
        @(posedge core_clk);
        fuse <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            @(posedge core_clk);
            dclk <= ~dclk;
            if (i == 2)
                nrst <= 1'b0;
            #1;
            chk({pad_oe[1:0], pad_out[1]}, {2'b10, dclk});
        end
        chk({pad_pullup, ss_n}, 9'h001);
        @(posedge core_clk);
        nrst <= 1'b1;
        fuse <= 1'b0;
        tick;
        tick;
        chk(pad_oe[1], 1'b0);
        $display("clock output test done");
    endtask

    // -------------------------------------------------------------------
    // Clock, sequence and watchdog
    // -------------------------------------------------------------------
    initial begin
        forever #2 core_clk = ~core_clk;
    end

    initial begin
        repeat (5) @(posedge core_clk);
        #1;
        chk({pad_oe, pad_pullup, ss_n}, 17'h00001);
        @(posedge core_clk);
        nrst <= 1'b1;
        t_plain;
        t_slave;
        t_compare;
        t_inputs;
        t_divided_clock_pin;
        end_sim;
    end

    // Whole run is about 70 cycles; this is ample margin
    initial begin
        #20000;
        err_total++;
        end_sim;
    end
endmodule // tb
